// File: dcai_map.vh
// command, address, bank and mode-register constants for the ddr2 input block
`ifndef DCAI_MAP_VH
`define DCAI_MAP_VH
`define DCAI_ADDR_W 14
`define DCAI_ADDR_W16 13
`define DCAI_BANK_W 3
`define DCAI_NBANK 8
`define DCAI_AP_BIT 10
`define DCAI_CMD_LMR 3'h0
`define DCAI_CMD_REF 3'h1
`define DCAI_CMD_PRE 3'h2
`define DCAI_CMD_ACT 3'h3
`define DCAI_CMD_WR 3'h4
`define DCAI_CMD_RD 3'h5
`define DCAI_CMD_NOP 3'h7
`define DCAI_MR_NUM 4
`endif

// File: dcai_sync.v
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module dcai_sync #(
  parameter W = 1
) (
  input wire CLK, // system clock
  input wire SYS_RST, // synchronous reset, active high
  input wire [W-1:0] D, // asynchronous levels
  output reg [W-1:0] Q // synchronised levels
);
  reg [W-1:0] meta_r;
  always @(posedge CLK) begin
    if (SYS_RST) begin
      meta_r <= {W{1'b0}};
      Q <= {W{1'b0}};
    end else begin
      meta_r <= D;
      Q <= meta_r;
    end
  end
endmodule // dcai_sync

// File: dcai_top.v
// ddr2 command, address and cke input decoder, device side
`timescale 1ns/1ps
`include "dcai_map.vh"
module dcai_top (
  input wire CLK, // 40 MHz system clock
  input wire SYS_RST, // synchronous reset, active high
  input wire CK, // memory clock, true side
  input wire CK_N, // memory clock, complement side
  input wire CKE, // clock enable pin
  input wire CS_N, // chip select, active low
  input wire RAS_N, // row strobe, active low
  input wire CAS_N, // column strobe, active low
  input wire WE_N, // write enable, active low
  input wire ODT, // termination enable pin
  input wire [2:0] BA, // bank address
  input wire [13:0] A, // address bus
  output reg [2:0] CMD, // decoded command code
  output reg CMD_VLD, // one-cycle pulse per accepted command other than nop
  output reg [2:0] BANK, // bank the command targets
  output reg [13:0] ROW, // row captured on activate
  output reg [13:0] COL, // column captured on read or write
  output reg AUTO_PRE, // auto-precharge flag of read or write
  output reg PRE_ALL, // precharge applies to all banks
  output reg [7:0] OPEN_BANKS, // bank has an open row
  output reg [1:0] MR_SEL, // mode register written on load mode
  output reg [13:0] MR_OPCODE, // op-code of last load mode
  output reg [3:0] MR_WR, // one-cycle write strobe per mode register
  output reg CLK_EN, // internal clocking enabled
  output reg PD_PRE, // precharge power-down
  output reg PD_ACT, // active power-down
  output reg SELF_REF, // self refresh
  output reg CMD_BUF_EN, // command and address receivers enabled
  output reg CK_BUF_EN, // clock and odt receivers enabled
  output reg ODT_EN, // registered termination enable
  output reg RD_EDGE // pulse on each CK crossing for read data timing
);
////////////////////////////////////////////////////////////////////////
  localparam ST_ACT = 4'h1;
  localparam ST_PPD = 4'h2;
  localparam ST_APD = 4'h4;
  localparam ST_SR = 4'h8;

  function [2:0] dcai_decode;
    input ras_n;
    input cas_n;
    input we_n;
    begin
      dcai_decode = {ras_n, cas_n, we_n};
    end
  endfunction

  // one-hot write strobe for the mode register picked by the bank bits
  function [3:0] dcai_mr_onehot;
    input [1:0] sel;
    begin
      dcai_mr_onehot = 4'h1 << sel;
    end
  endfunction

  wire [10:0] sync_q;
  dcai_sync #(.W(11)) u_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .D({CK, CK_N, CKE, CS_N, RAS_N, CAS_N, WE_N, ODT, BA}),
    .Q(sync_q)
  );
  wire ck_s = sync_q[10];
  wire ckn_s = sync_q[9];
  wire cke_s = sync_q[8];
  wire cs_n_s = sync_q[7];
  wire ras_s = sync_q[6];
  wire cas_s = sync_q[5];
  wire we_s = sync_q[4];
  wire odt_s = sync_q[3];
  wire [2:0] ba_s = sync_q[2:0];
  reg ck_prev_r;
  // one-hot power state; only the active state lets commands through
  reg [3:0] state_r;
  reg [3:0] state_nxt;
////////////////////////////////////////////////////////////////////////
  // the address bundle is taken from a separate synchroniser so the
  // bus width stays exact; sampling is qualified by the crossing below
  // x16 parts use only 13 address bits: the top input must be held low
  // there, or row, column and op-code pick up a stray bit
  wire [13:0] a_sync;
  dcai_sync #(.W(14)) u_sync_a (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .D(A),
    .Q(a_sync)
  );
  // rising crossing: CK went high while CK# is low
  // a crossing is seen once per ck period, so no command is taken twice
  wire pos_x = ck_s & ~ck_prev_r & ~ckn_s;
  wire neg_x = ~ck_s & ck_prev_r;
  wire in_buf_on = (state_r == ST_ACT);
  wire [2:0] code = dcai_decode(ras_s, cas_s, we_s);
  // cs high masks every command; receivers off in low-power states
  wire cmd_take = pos_x & in_buf_on & cke_s & ~cs_n_s;
  wire all_idle = (OPEN_BANKS == 8'h00);
  wire sr_req = (code == `DCAI_CMD_REF);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_ACT: begin
        // entry is judged on the crossing that registers CKE low
        if (pos_x & ~cke_s) begin
          if (!all_idle)
            state_nxt = ST_APD;
          else if (~cs_n_s & sr_req)
            state_nxt = ST_SR;
          else
            state_nxt = ST_PPD;
        end
      end
      ST_PPD, ST_APD: begin
        if (pos_x & cke_s)
          state_nxt = ST_ACT;
      end
      ST_SR: begin
        // clock may be stopped; exit follows the pin level alone
        if (cke_s)
          state_nxt = ST_ACT;
      end
      default: state_nxt = ST_ACT;
    endcase
  end
////////////////////////////////////////////////////////////////////////
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ck_prev_r <= 1'b0;
      state_r <= ST_ACT;
      CMD <= `DCAI_CMD_NOP;
      CMD_VLD <= 1'b0;
      BANK <= 3'h0;
      ROW <= 14'h0000;
      COL <= 14'h0000;
      AUTO_PRE <= 1'b0;
      PRE_ALL <= 1'b0;
      OPEN_BANKS <= 8'h00;
      MR_SEL <= 2'h0;
      MR_OPCODE <= 14'h0000;
      MR_WR <= 4'h0;
      CLK_EN <= 1'b0;
      PD_PRE <= 1'b0;
      PD_ACT <= 1'b0;
      SELF_REF <= 1'b0;
      CMD_BUF_EN <= 1'b1;
      CK_BUF_EN <= 1'b1;
      ODT_EN <= 1'b0;
      RD_EDGE <= 1'b0;
    end else begin
      ck_prev_r <= ck_s;
      state_r <= state_nxt;
      CMD_VLD <= 1'b0;
      MR_WR <= 4'h0;
      // both crossings are passed on as they come: read timing built on them
      // holds only with the delay-locked loop on, and both byte lanes share it
      RD_EDGE <= pos_x | neg_x;
      CLK_EN <= (state_nxt == ST_ACT);
      PD_PRE <= (state_nxt == ST_PPD);
      PD_ACT <= (state_nxt == ST_APD);
      SELF_REF <= (state_nxt == ST_SR);
      CMD_BUF_EN <= (state_nxt == ST_ACT);
      CK_BUF_EN <= (state_nxt != ST_SR);
      if (pos_x && state_nxt != ST_SR)
        ODT_EN <= odt_s;
      if (cmd_take) begin
        CMD <= code;
        CMD_VLD <= (code != `DCAI_CMD_NOP);
        BANK <= ba_s;
        case (code)
          `DCAI_CMD_ACT: begin
            ROW <= a_sync;
            OPEN_BANKS[ba_s] <= 1'b1;
          end
          `DCAI_CMD_RD, `DCAI_CMD_WR: begin
            COL <= a_sync;
            AUTO_PRE <= a_sync[`DCAI_AP_BIT];
            // the bank is marked closed at once, not after the burst: this map
            // tracks only what the command bus has asked for
            if (a_sync[`DCAI_AP_BIT])
              OPEN_BANKS[ba_s] <= 1'b0;
          end
          `DCAI_CMD_PRE: begin
            PRE_ALL <= a_sync[`DCAI_AP_BIT];
            if (a_sync[`DCAI_AP_BIT])
              OPEN_BANKS <= 8'h00;
            else
              OPEN_BANKS[ba_s] <= 1'b0;
          end
          `DCAI_CMD_LMR: begin
            MR_SEL <= ba_s[1:0];
            MR_OPCODE <= a_sync;
            MR_WR <= dcai_mr_onehot(ba_s[1:0]);
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule // dcai_top

// File: dcai_props.sv
// assertions on the ddr2 command decoder outputs
`timescale 1ns/1ps
`include "dcai_map.vh"
module dcai_props (
  input wire CLK, // system clock
  input wire SYS_RST, // synchronous reset, active high
  input wire CMD_VLD, // command pulse
  input wire PRE_ALL, // precharge of all banks
  input wire CLK_EN, // internal clocking on
  input wire PD_PRE, // precharge power-down
  input wire PD_ACT, // active power-down
  input wire SELF_REF, // self refresh
  input wire CMD_BUF_EN, // command receivers on
  input wire CK_BUF_EN, // clock receivers on
  input wire [2:0] CMD, // decoded command
  input wire [2:0] BANK, // target bank
  input wire [7:0] OPEN_BANKS, // open row map
  input wire [1:0] MR_SEL, // mode register pick
  input wire [3:0] MR_WR // mode register strobes
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_vld_pulse: assert property (CMD_VLD |-> CMD != `DCAI_CMD_NOP ##1 !CMD_VLD)
    else $error("command pulse wrong");
  a_mr_strobe: assert property (MR_WR != 4'h0 |-> MR_WR == (4'h1 << MR_SEL))
    else $error("mode strobe wrong");
  a_act_opens: assert property (CMD_VLD && CMD == `DCAI_CMD_ACT |-> OPEN_BANKS[BANK])
    else $error("bank not opened");
  a_pre_all: assert property (CMD_VLD && CMD == `DCAI_CMD_PRE && PRE_ALL |-> OPEN_BANKS == 8'h00)
    else $error("banks left open");
  a_pre_one: assert property (CMD_VLD && CMD == `DCAI_CMD_PRE |-> !OPEN_BANKS[BANK])
    else $error("bank not closed");
  a_apd_open: assert property (PD_ACT |-> OPEN_BANKS != 8'h00)
    else $error("active power-down with no row");
  a_pd_bufs: assert property (PD_PRE || PD_ACT |-> !CMD_BUF_EN && CK_BUF_EN && !CMD_VLD)
    else $error("power-down receivers wrong");
  a_sr_bufs: assert property (SELF_REF |-> !CMD_BUF_EN && !CK_BUF_EN && !CLK_EN)
    else $error("self refresh receivers wrong");
  c_act: cover property (CMD_VLD && CMD == `DCAI_CMD_ACT);
  c_apd: cover property (PD_ACT);
  c_sref: cover property (SELF_REF);
endmodule // dcai_props
bind dcai_top dcai_props chk (.*);

// File: dcai_ctl_model.sv
// controller model driving the ddr2 command pins
`timescale 1ns/1ps
module dcai_ctl_model (
  input wire CLK, // system clock
  output reg CK = 1'b0, // memory clock
  output reg CK_N = 1'b1, // its complement
  output reg CKE = 1'b0, // clock enable
  output reg ODT = 1'b0, // termination enable
  output reg CS_N = 1'b1, // chip select
  output reg RAS_N = 1'b1, // row strobe
  output reg CAS_N = 1'b1, // column strobe
  output reg WE_N = 1'b1, // write enable
  output reg [2:0] BA = 3'h0, // bank address
  output reg [13:0] A = 14'h0 // address bus
);
  // one command per ck period; ck stands still between commands
  // only the command side is modelled: no data lanes are driven, as a
  // one-byte user of a x16 part keeps to the lower lane
  // the run stays in the normal temperature range, so refresh keeps its
  // base rate and the standard self-refresh option is used
  task issue(input [2:0] c, input cs, input ke, input [2:0] b, input [13:0] a);
    begin
      @(negedge CLK);
      CS_N <= cs;
      {RAS_N, CAS_N, WE_N} <= c;
      CKE <= ke;
      ODT <= ke;
      BA <= b;
      A <= a;
      // three cycles of setup and four high keep the ck period at 200 ns
      repeat (3) @(negedge CLK);
      {CK, CK_N} <= 2'b10;
      repeat (4) @(negedge CLK);
      {CK, CK_N} <= 2'b01;
      CS_N <= 1'b1;
      // released lines show the inverse so stale values never look valid
      BA <= ~b;
      A <= ~a;
    end
  endtask
  task wake;
    begin
      @(negedge CLK);
      CKE <= 1'b1;
    end
  endtask
endmodule // dcai_ctl_model

// File: test_dcai_top.sv
// testbench for the ddr2 command, address and cke decoder
`timescale 1ns/1ps
`include "dcai_map.vh"
module test_dcai_top;
  reg CLK = 1'b0;
  reg SYS_RST = 1'b1;
  wire CK, CK_N, CKE, CS_N, RAS_N, CAS_N, WE_N, ODT, CMD_VLD, AUTO_PRE, PRE_ALL, CLK_EN;
  wire PD_PRE, PD_ACT, SELF_REF, CMD_BUF_EN, CK_BUF_EN, ODT_EN, RD_EDGE;
  wire [2:0] BA, CMD, BANK;
  wire [13:0] A, ROW, COL, MR_OPCODE;
  wire [7:0] OPEN_BANKS;
  wire [1:0] MR_SEL;
  wire [3:0] MR_WR;
  integer failures = 0, checks_done = 0, cyc = 0, i, edges = 0;
  reg [19:0] exp_q[$];
  reg [19:0] e;
  reg ok;
  dcai_ctl_model ctl (.*);
  dcai_top uut (.*);
  initial forever #12.5 CLK = ~CLK;
  task check(input v);
    begin
      checks_done = checks_done + 1;
      if (v !== 1'b1) begin
        failures = failures + 1;
        $display("ERROR %0t output mismatch", $time);
      end
    end
  endtask
  task cmd(input [2:0] c, input [2:0] b, input [13:0] a);
    begin
      exp_q.push_back({c, b, a});
      ctl.issue(c, 1'b0, 1'b1, b, a);
    end
  endtask
  task end_of_test;
    begin
      if (failures == 0 && checks_done > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(negedge CLK) begin
    if (CMD_VLD === 1'b1) begin
      e = exp_q.size() ? exp_q.pop_front() : 20'hfffff;
      case (e[19:17])
        `DCAI_CMD_ACT: ok = ROW === e[13:0];
        `DCAI_CMD_RD, `DCAI_CMD_WR: ok = COL === e[13:0] && AUTO_PRE === e[10];
        `DCAI_CMD_PRE: ok = PRE_ALL === e[10];
        `DCAI_CMD_LMR: ok = MR_OPCODE === e[13:0] && MR_SEL === e[15:14];
        default: ok = 1'b0;
      endcase
      check(ok && CMD === e[19:17] && (e[19:18] == 2'b00 || BANK === e[16:14]));
    end
  end
  always @(negedge CLK) begin
    if (RD_EDGE === 1'b1)
      edges = edges + 1;
  end
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    i = $urandom(68);
    repeat (10) @(negedge CLK);
    SYS_RST = 1'b0;
    repeat (3) @(negedge CLK);
    check(CLK_EN === 1'b1 && CMD_BUF_EN === 1'b1);
    for (i = 0; i < 4; i = i + 1)
      cmd(`DCAI_CMD_LMR, i[2:0], 14'($urandom));
    cmd(`DCAI_CMD_ACT, 3'h2, 14'($urandom));
    cmd(`DCAI_CMD_RD, 3'h2, 14'h0123);
    cmd(`DCAI_CMD_ACT, 3'h5, 14'($urandom));
    cmd(`DCAI_CMD_WR, 3'h5, 14'h0400 | 14'($urandom));
    cmd(`DCAI_CMD_ACT, 3'h5, 14'($urandom));
    cmd(`DCAI_CMD_PRE, 3'h2, 14'h0000);
    check(OPEN_BANKS === 8'h20 && ODT_EN === 1'b1);
    ctl.issue(`DCAI_CMD_ACT, 1'b1, 1'b1, 3'h0, 14'h0);
    ctl.issue(`DCAI_CMD_NOP, 1'b0, 1'b0, 3'h0, 14'h0);
    check(PD_ACT === 1'b1 && CK_BUF_EN === 1'b1 && CLK_EN === 1'b0 && ODT_EN === 1'b0);
    ctl.issue(`DCAI_CMD_PRE, 1'b0, 1'b0, 3'h5, 14'h0400);
    ctl.issue(`DCAI_CMD_NOP, 1'b0, 1'b1, 3'h0, 14'h0);
    check(PD_ACT === 1'b0 && OPEN_BANKS === 8'h20);
    cmd(`DCAI_CMD_PRE, 3'h0, 14'h0400);
    ctl.issue(`DCAI_CMD_NOP, 1'b0, 1'b0, 3'h0, 14'h0);
    check(PD_PRE === 1'b1 && CMD_BUF_EN === 1'b0);
    ctl.issue(`DCAI_CMD_NOP, 1'b0, 1'b1, 3'h0, 14'h0);
    ctl.issue(`DCAI_CMD_REF, 1'b0, 1'b0, 3'h0, 14'h0);
    check(SELF_REF === 1'b1 && CK_BUF_EN === 1'b0);
    ctl.wake;
    repeat (6) @(negedge CLK);
    check(SELF_REF === 1'b0 && CLK_EN === 1'b1);
    edges = 0;
    cmd(`DCAI_CMD_ACT, 3'h7, 14'($urandom));
    check(exp_q.size() == 0);
    repeat (4) @(negedge CLK);
    check(edges == 2);
    end_of_test;
  end
endmodule // test_dcai_top
